// *** hdl/vpdeu_pkg.sv ***
/*
 * Constants for the VGA port decoder with extension unlock.
 * Assumes a 10-bit ISA I/O address and one 8-bit data lane.
 */
package vpdeu_pkg;

    // ==================================================
    // I/O port addresses
    localparam logic [9:0] PORT_CRTC_IDX_MONO = 10'h3b4;
    localparam logic [9:0] PORT_CRTC_DAT_MONO = 10'h3b5;
    localparam logic [9:0] PORT_CRTC_IDX_COLOR = 10'h3d4;
    localparam logic [9:0] PORT_CRTC_DAT_COLOR = 10'h3d5;
    localparam logic [9:0] PORT_STAT1_MONO = 10'h3ba;
    localparam logic [9:0] PORT_STAT1_COLOR = 10'h3da;
    localparam logic [9:0] PORT_ATTR_WR = 10'h3c0;
    localparam logic [9:0] PORT_ATTR_RD = 10'h3c1;
    localparam logic [9:0] PORT_MISC_STAT0 = 10'h3c2;
    localparam logic [9:0] PORT_VGA_EN = 10'h3c3;
    localparam logic [9:0] PORT_SEQ_IDX = 10'h3c4;
    localparam logic [9:0] PORT_SEQ_DAT = 10'h3c5;
    localparam logic [9:0] PORT_PEL_MASK = 10'h3c6;
    localparam logic [9:0] PORT_DAC_RADDR = 10'h3c7;
    localparam logic [9:0] PORT_DAC_WADDR = 10'h3c8;
    localparam logic [9:0] PORT_DAC_DATA = 10'h3c9;
    localparam logic [9:0] PORT_FEAT_RB = 10'h3ca;
    localparam logic [9:0] PORT_MISC_RB = 10'h3cc;
    localparam logic [9:0] PORT_GFX_IDX = 10'h3ce;
    localparam logic [9:0] PORT_GFX_DAT = 10'h3cf;

    // ==================================================
    // Graphics-port indices and extension codes
    localparam logic [7:0] EXT_UNLOCK_IDX = 8'h0a;
    localparam logic [7:0] ATTR_MIRROR_IDX = 8'h0b;
    localparam logic [7:0] GFX_STD_LAST = 8'h08;
    localparam logic [7:0] EXT_ENABLE_CODE = 8'hec;
    localparam logic [7:0] EXT_DISABLE_CODE = 8'hce;
    localparam logic [7:0] CRTC_LAST = 8'h1f;
    localparam logic [4:0] OVERSCAN_IDX = 5'h11;
    localparam logic [7:0] FLOAT_DATA = 8'hff;

    // ==================================================
    // Field positions
    localparam int MISC_COLOR_BIT = 0;
    localparam int MIRROR_FF_BIT = 7;
    localparam int MIRROR_VEN_BIT = 5;
    localparam logic [2:0] HIDDEN_READS = 3'h4;
    localparam logic [1:0] DAC_LAST_COMP = 2'h2;
    localparam logic [1:0] DAC_STATE_RD = 2'h3;
    localparam logic [1:0] DAC_STATE_WR = 2'h0;

    // ==================================================
    // State
    typedef struct packed {
        logic [7:0] misc;
        logic [7:0] feat;
        logic vga_en;
        logic [7:0] crtc_idx;
        logic [7:0] seq_idx;
        logic [7:0] gfx_idx;
        logic [4:0] attr_idx;
        logic attr_ff;
        logic video_en;
        logic ext_en;
        logic [7:0] pel_mask;
        logic [7:0] hidden;
        logic [2:0] hid_cnt;
        logic dac_rd_mode;
        logic [7:0] dac_raddr;
        logic [7:0] dac_waddr;
        logic [1:0] dac_rcnt;
        logic [1:0] dac_wcnt;
        logic [5:0] dac_red;
        logic [5:0] dac_grn;
        logic [7:0] rdata;
        logic rvalid;
        logic [17:0] rgb;
    } vpdeu_state_s;

    localparam vpdeu_state_s STATE_RST = '0;

endpackage

// *** hdl/vpdeu_top.sv ***
/*
 * VGA I/O port decoder with extension unlock and attribute index mirror.
 * Assumes one-cycle read/write strobes synchronous to clk_sys_in that
 * never occur together; read data follows one cycle after the strobe.
 */
// Contract
// (RULE1) CRTC ports at 3B4/3B5 mono, 3D4/3D5 colour
// (RULE2) Attribute write at 3C0, read at 3C1
// (RULE3) 3C2 misc write, status0 read, 3CC readback
// (RULE4) 3BA/3DA feature write, status1 read, 3CA readback
// (RULE5) Sequencer index 3C4, data 3C5
// (RULE6) Graphics index 3CE, data 3CF, extensions too
// (RULE7) Palette ports 3C6 to 3C9
// (RULE8) Writing EC to index 0A opens extensions
// (RULE9) Unlock reads 01 while open
// (RULE10) Writing CE closes, reads 00
// (RULE11) Bit 0 is access flag, rest zero
// (RULE12) Mirror bit 7 reads/forces attribute flip-flop
// (RULE13) Mirror bits 4:0 are attribute index
// (RULE14) Video enable low shows overscan colour
// (RULE15) Palette dual-ported, host access any time
// (RULE16) Other codes keep flag; locked extensions ignored
module vpdeu_top (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [9:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] status0_in,
    input wire logic [7:0] status1_in,
    input wire logic [7:0] vid_pixel_in,
    output logic [7:0] io_rdata_out,
    output logic io_rvalid_out,
    output logic [17:0] vid_rgb_out,
    output logic ext_access_out,
    output logic video_en_out
);
    import vpdeu_pkg::*;

    // ==================================================
    // Storage
    vpdeu_state_s r;
    vpdeu_state_s n;
    logic [7:0] crtc_mem [0:31];
    logic [7:0] seq_mem [0:7];
    logic [7:0] gfx_mem [0:15];
    logic [7:0] attr_mem [0:31];
    logic [17:0] palette [0:255];

    logic mono;
    logic [9:0] crtc_idx_port;
    logic [9:0] crtc_dat_port;
    logic [9:0] stat1_port;
    logic crtc_we;
    logic seq_we;
    logic gfx_we;
    logic attr_we;
    logic pal_we;
    logic [17:0] pal_wd;
    logic [17:0] pal_rd;
    logic [17:0] ovs_rgb;
    logic is_pel;

    // ==================================================
    // Decode
    always_comb begin
        mono = ~r.misc[MISC_COLOR_BIT];
        crtc_idx_port = mono ? PORT_CRTC_IDX_MONO : PORT_CRTC_IDX_COLOR; // RULE1
        crtc_dat_port = mono ? PORT_CRTC_DAT_MONO : PORT_CRTC_DAT_COLOR; // RULE1
        stat1_port = mono ? PORT_STAT1_MONO : PORT_STAT1_COLOR; // RULE4
        pal_rd = palette[r.dac_raddr];
        ovs_rgb = palette[attr_mem[OVERSCAN_IDX]];
        is_pel = (io_addr_in == PORT_PEL_MASK);
    end

    // ==================================================
    // Next state
    always_comb begin
        n = r;
        crtc_we = 1'b0;
        seq_we = 1'b0;
        gfx_we = 1'b0;
        attr_we = 1'b0;
        pal_we = 1'b0;
        pal_wd = {r.dac_red, r.dac_grn, io_wdata_in[5:0]};
        n.rvalid = io_rd_in;
        n.rdata = io_rd_in ? FLOAT_DATA : r.rdata;
        // Hidden DAC unlock needs back-to-back reads of the mask port
        if ((io_rd_in || io_wr_in) && !is_pel) begin
            n.hid_cnt = 3'h0;
        end
        if (io_wr_in) begin
            if (io_addr_in == crtc_idx_port) begin
                n.crtc_idx = io_wdata_in; // RULE1
            end else if (io_addr_in == crtc_dat_port) begin
                crtc_we = (r.crtc_idx <= CRTC_LAST); // RULE1
            end else if (io_addr_in == stat1_port) begin
                n.feat = io_wdata_in; // RULE4
            end else if (io_addr_in == PORT_ATTR_WR) begin
                if (!r.attr_ff) begin
                    n.attr_idx = io_wdata_in[4:0]; // RULE2
                    n.video_en = io_wdata_in[MIRROR_VEN_BIT];
                end else begin
                    attr_we = 1'b1; // RULE2
                end
                n.attr_ff = ~r.attr_ff;
            end else if (io_addr_in == PORT_MISC_STAT0) begin
                n.misc = io_wdata_in; // RULE3
            end else if (io_addr_in == PORT_VGA_EN) begin
                n.vga_en = io_wdata_in[0];
            end else if (io_addr_in == PORT_SEQ_IDX) begin
                n.seq_idx = io_wdata_in; // RULE5
            end else if (io_addr_in == PORT_SEQ_DAT) begin
                seq_we = 1'b1; // RULE5
            end else if (is_pel) begin
                if (r.hid_cnt == HIDDEN_READS) begin
                    n.hidden = io_wdata_in; // RULE7
                end else begin
                    n.pel_mask = io_wdata_in; // RULE7
                end
                n.hid_cnt = 3'h0;
            end else if (io_addr_in == PORT_DAC_RADDR) begin
                n.dac_raddr = io_wdata_in; // RULE7
                n.dac_rcnt = 2'h0;
                n.dac_rd_mode = 1'b1;
            end else if (io_addr_in == PORT_DAC_WADDR) begin
                n.dac_waddr = io_wdata_in; // RULE7
                n.dac_wcnt = 2'h0;
                n.dac_rd_mode = 1'b0;
            end else if (io_addr_in == PORT_DAC_DATA) begin
                case (r.dac_wcnt)
                    2'h0: n.dac_red = io_wdata_in[5:0];
                    2'h1: n.dac_grn = io_wdata_in[5:0];
                    default: pal_we = 1'b1; // RULE15
                endcase
                if (r.dac_wcnt == DAC_LAST_COMP) begin
                    n.dac_wcnt = 2'h0;
                    n.dac_waddr = r.dac_waddr + 8'h01;
                end else begin
                    n.dac_wcnt = r.dac_wcnt + 2'h1;
                end
            end else if (io_addr_in == PORT_GFX_IDX) begin
                n.gfx_idx = io_wdata_in; // RULE6
            end else if (io_addr_in == PORT_GFX_DAT) begin
                if (r.gfx_idx == EXT_UNLOCK_IDX) begin
                    if (io_wdata_in == EXT_ENABLE_CODE) begin
                        n.ext_en = 1'b1; // RULE8
                    end else if (io_wdata_in == EXT_DISABLE_CODE) begin
                        n.ext_en = 1'b0; // RULE10
                    end
                end else if (r.gfx_idx == ATTR_MIRROR_IDX) begin
                    if (r.ext_en) begin // RULE16
                        n.attr_ff = io_wdata_in[MIRROR_FF_BIT]; // RULE12
                        n.video_en = io_wdata_in[MIRROR_VEN_BIT];
                        n.attr_idx = io_wdata_in[4:0]; // RULE13
                    end
                end else if (r.gfx_idx <= GFX_STD_LAST) begin
                    gfx_we = 1'b1; // RULE6
                end
            end
        end
        if (io_rd_in) begin
            if (io_addr_in == crtc_idx_port) begin
                n.rdata = r.crtc_idx; // RULE1
            end else if (io_addr_in == crtc_dat_port) begin
                n.rdata = (r.crtc_idx <= CRTC_LAST) ?
                    crtc_mem[r.crtc_idx[4:0]] : 8'h00;
            end else if (io_addr_in == stat1_port) begin
                n.rdata = status1_in; // RULE4
                n.attr_ff = 1'b0;
            end else if (io_addr_in == PORT_ATTR_WR) begin
                n.rdata = {2'b00, r.video_en, r.attr_idx};
            end else if (io_addr_in == PORT_ATTR_RD) begin
                n.rdata = attr_mem[r.attr_idx]; // RULE2
            end else if (io_addr_in == PORT_MISC_STAT0) begin
                n.rdata = status0_in; // RULE3
            end else if (io_addr_in == PORT_VGA_EN) begin
                n.rdata = {7'h00, r.vga_en};
            end else if (io_addr_in == PORT_SEQ_IDX) begin
                n.rdata = r.seq_idx; // RULE5
            end else if (io_addr_in == PORT_SEQ_DAT) begin
                n.rdata = seq_mem[r.seq_idx[2:0]]; // RULE5
            end else if (is_pel) begin
                if (r.hid_cnt == HIDDEN_READS) begin
                    n.rdata = r.hidden; // RULE7
                end else begin
                    n.rdata = r.pel_mask; // RULE7
                    n.hid_cnt = r.hid_cnt + 3'h1;
                end
            end else if (io_addr_in == PORT_DAC_RADDR) begin
                n.rdata = {6'h00,
                    r.dac_rd_mode ? DAC_STATE_RD : DAC_STATE_WR}; // RULE7
            end else if (io_addr_in == PORT_DAC_WADDR) begin
                n.rdata = r.dac_waddr; // RULE7
            end else if (io_addr_in == PORT_DAC_DATA) begin
                case (r.dac_rcnt)
                    2'h0: n.rdata = {2'b00, pal_rd[17:12]}; // RULE15
                    2'h1: n.rdata = {2'b00, pal_rd[11:6]};
                    default: n.rdata = {2'b00, pal_rd[5:0]};
                endcase
                if (r.dac_rcnt == DAC_LAST_COMP) begin
                    n.dac_rcnt = 2'h0;
                    n.dac_raddr = r.dac_raddr + 8'h01;
                end else begin
                    n.dac_rcnt = r.dac_rcnt + 2'h1;
                end
            end else if (io_addr_in == PORT_FEAT_RB) begin
                n.rdata = r.feat; // RULE4
            end else if (io_addr_in == PORT_MISC_RB) begin
                n.rdata = r.misc; // RULE3
            end else if (io_addr_in == PORT_GFX_IDX) begin
                n.rdata = r.gfx_idx; // RULE6
            end else if (io_addr_in == PORT_GFX_DAT) begin
                if (r.gfx_idx == EXT_UNLOCK_IDX) begin
                    n.rdata = {7'h00, r.ext_en}; // RULE9 RULE10 RULE11
                end else if (r.gfx_idx == ATTR_MIRROR_IDX) begin
                    n.rdata = r.ext_en ? {r.attr_ff, 1'b0, r.video_en,
                        r.attr_idx} : 8'h00; // RULE12 RULE13
                end else if (r.gfx_idx <= GFX_STD_LAST) begin
                    n.rdata = gfx_mem[r.gfx_idx[3:0]];
                end else begin
                    n.rdata = 8'h00;
                end
            end
        end
        // Video side reads its own palette port, never the host one
        n.rgb = r.video_en ? palette[vid_pixel_in & r.pel_mask] :
            ovs_rgb; // RULE14 RULE15
    end

    // ==================================================
    // Registers
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            r <= STATE_RST;
        end else begin
            r <= n;
        end
    end

    // Register arrays hold no reset, as in a RAM
    always_ff @(posedge clk_sys_in) begin
        if (crtc_we) begin
            crtc_mem[r.crtc_idx[4:0]] <= io_wdata_in;
        end
        if (seq_we) begin
            seq_mem[r.seq_idx[2:0]] <= io_wdata_in;
        end
        if (gfx_we) begin
            gfx_mem[r.gfx_idx[3:0]] <= io_wdata_in;
        end
        if (attr_we) begin
            attr_mem[r.attr_idx] <= io_wdata_in;
        end
        if (pal_we) begin
            palette[r.dac_waddr] <= pal_wd; // RULE15
        end
    end

    assign io_rdata_out = r.rdata;
    assign io_rvalid_out = r.rvalid;
    assign vid_rgb_out = r.rgb;
    assign ext_access_out = r.ext_en;
    assign video_en_out = r.video_en;

    // ==================================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);

    logic gfx_dat_wr;
    logic gfx_dat_rd;
    assign gfx_dat_wr = io_wr_in && (io_addr_in == PORT_GFX_DAT);
    assign gfx_dat_rd = io_rd_in && (io_addr_in == PORT_GFX_DAT);

    property p_crtc_mono;
        mono && io_wr_in && (io_addr_in == PORT_CRTC_IDX_COLOR)
            |=> $stable(r.crtc_idx);
    endproperty
    a_crtc_mono: assert property (p_crtc_mono) // RULE1
        else $error("colour CRTC port decoded in mono mode");

    property p_attr_toggle;
        io_wr_in && (io_addr_in == PORT_ATTR_WR) && !io_rd_in
            |=> r.attr_ff != $past(r.attr_ff);
    endproperty
    a_attr_toggle: assert property (p_attr_toggle) // RULE2
        else $error("attribute flip-flop did not toggle");

    property p_misc_rb;
        io_rd_in && (io_addr_in == PORT_MISC_RB)
            |=> io_rvalid_out && io_rdata_out == $past(r.misc);
    endproperty
    a_misc_rb: assert property (p_misc_rb) // RULE3
        else $error("misc output readback wrong");

    property p_feat_rb;
        io_rd_in && (io_addr_in == PORT_FEAT_RB)
            |=> io_rdata_out == $past(r.feat);
    endproperty
    a_feat_rb: assert property (p_feat_rb) // RULE4
        else $error("feature control readback wrong");

    property p_unlock_en;
        gfx_dat_wr && r.gfx_idx == EXT_UNLOCK_IDX &&
            io_wdata_in == EXT_ENABLE_CODE |=> ext_access_out;
    endproperty
    a_unlock_en: assert property (p_unlock_en) // RULE8
        else $error("enable code did not open extensions");

    property p_unlock_rd;
        gfx_dat_rd && r.gfx_idx == EXT_UNLOCK_IDX && r.ext_en
            |=> io_rdata_out == 8'h01;
    endproperty
    a_unlock_rd: assert property (p_unlock_rd) // RULE9
        else $error("unlock register did not read 01");

    property p_unlock_dis;
        gfx_dat_wr && r.gfx_idx == EXT_UNLOCK_IDX &&
            io_wdata_in == EXT_DISABLE_CODE |=> !ext_access_out;
    endproperty
    a_unlock_dis: assert property (p_unlock_dis) // RULE10
        else $error("disable code did not close extensions");

    property p_unlock_zero;
        gfx_dat_rd && r.gfx_idx == EXT_UNLOCK_IDX && !r.ext_en
            |=> io_rdata_out == 8'h00;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero) // RULE11
        else $error("locked unlock register not zero");

    property p_mirror_wr;
        gfx_dat_wr && r.gfx_idx == ATTR_MIRROR_IDX && r.ext_en
            |=> r.attr_ff == $past(io_wdata_in[7]) &&
            r.attr_idx == $past(io_wdata_in[4:0]);
    endproperty
    a_mirror_wr: assert property (p_mirror_wr) // RULE12 RULE13
        else $error("mirror write did not force attribute state");

    logic ovs_seen_r;
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ovs_seen_r <= 1'b0;
        end else if (attr_we && r.attr_idx == OVERSCAN_IDX) begin
            ovs_seen_r <= 1'b1;
        end
    end
    property p_overscan;
        !r.video_en && ovs_seen_r |=> vid_rgb_out == $past(ovs_rgb);
    endproperty
    a_overscan: assert property (p_overscan) // RULE14
        else $error("overscan colour not shown while video off");

    property p_locked;
        gfx_dat_wr && r.gfx_idx != EXT_UNLOCK_IDX
            |=> $stable(ext_access_out);
    endproperty
    a_locked: assert property (p_locked) // RULE16
        else $error("extension flag changed by other write");

    c_unlock: cover property (gfx_dat_wr && r.gfx_idx == EXT_UNLOCK_IDX
        && io_wdata_in == EXT_ENABLE_CODE);
    c_mirror: cover property (gfx_dat_wr && r.gfx_idx == ATTR_MIRROR_IDX
        && r.ext_en);
    c_pal: cover property (pal_we);
    c_hidden: cover property (io_rd_in && is_pel
        && r.hid_cnt == HIDDEN_READS);

endmodule

// *** verif/vga_port_decode_ext_unlock_tb.sv ***
/*
 * Self-checking bench for the VGA port decoder with extension unlock.
 * Assumes the host model in vpdeu_host and one read answer per read.
 */
module vga_port_decode_ext_unlock_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import vpdeu_pkg::*;

    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [9:0] io_addr_in;
    logic io_wr_in;
    logic io_rd_in;
    logic [7:0] io_wdata_in;
    logic [7:0] status0_in;
    logic [7:0] status1_in;
    logic [7:0] vid_pixel_in;
    logic [7:0] io_rdata_out;
    logic io_rvalid_out;
    logic [17:0] vid_rgb_out;
    logic ext_access_out;
    logic video_en_out;
    logic [7:0] exp_q[$];
    logic [15:0] lfsr;
    logic [7:0] d;
    logic [7:0] a;
    logic [7:0] rgb[6];
    logic [9:0] stat1;
    logic [9:0] crtc_i;
    logic [9:0] crtc_o;
    int fail_count = 0;
    int n_checks = 0;

    always #2.5 clk_sys_in = ~clk_sys_in;

    vpdeu_top u_dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
        .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
        .status0_in(status0_in), .status1_in(status1_in),
        .vid_pixel_in(vid_pixel_in), .io_rdata_out(io_rdata_out),
        .io_rvalid_out(io_rvalid_out), .vid_rgb_out(vid_rgb_out),
        .ext_access_out(ext_access_out), .video_en_out(video_en_out)
    );

    vpdeu_host u_host (
        .clk_in(clk_sys_in), .io_addr_out(io_addr_in),
        .io_wr_out(io_wr_in), .io_rd_out(io_rd_in),
        .io_wdata_out(io_wdata_in)
    );

    // ==============================================================
    // Helpers
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [9:0] addr, input logic [7:0] data);
        u_host.access(addr, 1'b1, data);
    endtask

    task automatic rd(input logic [9:0] addr, input logic [7:0] exp);
        exp_q.push_back(exp);
        u_host.access(addr, 1'b0, 8'h00);
    endtask

    task automatic gwr(input logic [7:0] idx, input logic [7:0] data);
        wr(PORT_GFX_IDX, idx);
        wr(PORT_GFX_DAT, data);
    endtask

    task automatic grd(input logic [7:0] idx, input logic [7:0] exp);
        wr(PORT_GFX_IDX, idx);
        rd(PORT_GFX_DAT, exp);
    endtask

    task automatic test_done();
        // Reads that never got an answer count against the run
        if (exp_q.size() != 0)
            fail_count++;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==============================================================
    // Answer monitor: oldest note against each read answer
    always @(negedge clk_sys_in) begin
        if (io_rvalid_out === 1'b1) begin
            if (exp_q.size() > 0)
                check(io_rdata_out, exp_q.pop_front());
            else
                check(18'h0_0001, 18'h0_0000);
        end
    end

    initial begin
        #(5 * 4000);
        check(18'h0_0000, 18'h0_0001);
        test_done();
    end

    // ==============================================================
    // Main sequence
    initial begin
        lfsr = 16'h364e;
        status0_in = 8'h00;
        status1_in = 8'h00;
        vid_pixel_in = 8'h00;
        repeat (8) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        check(ext_access_out, 1'b0);
        grd(EXT_UNLOCK_IDX, 8'h00);
        gwr(ATTR_MIRROR_IDX, 8'h85);
        grd(ATTR_MIRROR_IDX, 8'h00);
        u_host.set_ext(1'b1);
        check(ext_access_out, 1'b1);
        grd(EXT_UNLOCK_IDX, 8'h01);
        d = rnd();
        while (d == EXT_ENABLE_CODE || d == EXT_DISABLE_CODE)
            d = rnd();
        gwr(EXT_UNLOCK_IDX, d);
        grd(EXT_UNLOCK_IDX, 8'h01);
        u_host.set_ext(1'b0);
        check(ext_access_out, 1'b0);
        grd(EXT_UNLOCK_IDX, 8'h00);
        gwr(EXT_UNLOCK_IDX, 8'h01);
        grd(EXT_UNLOCK_IDX, 8'h00);
        $display("unlock test done");

        u_host.set_ext(1'b1);
        status1_in = rnd();
        gwr(ATTR_MIRROR_IDX, 8'ha3);
        check(video_en_out, 1'b1);
        grd(ATTR_MIRROR_IDX, 8'ha3);
        rd(PORT_STAT1_MONO, status1_in);
        grd(ATTR_MIRROR_IDX, 8'h23);
        $display("mirror test done");

        // Misc bit 0 moves the CRTC and status 1 ports
        for (int i = 0; i < 2; i++) begin
            status0_in = rnd();
            status1_in = rnd();
            d = rnd();
            wr(PORT_MISC_STAT0, {d[7:1], i[0]});
            rd(PORT_MISC_RB, {d[7:1], i[0]});
            rd(PORT_MISC_STAT0, status0_in);
            stat1 = i[0] ? PORT_STAT1_COLOR : PORT_STAT1_MONO;
            crtc_i = i[0] ? PORT_CRTC_IDX_COLOR : PORT_CRTC_IDX_MONO;
            crtc_o = i[0] ? PORT_CRTC_IDX_MONO : PORT_CRTC_IDX_COLOR;
            d = rnd();
            wr(stat1, d);
            rd(PORT_FEAT_RB, d);
            rd(stat1, status1_in);
            wr(crtc_i, 8'h0c);
            wr(crtc_o, 8'h13);
            rd(crtc_i, 8'h0c);
            rd(crtc_o, FLOAT_DATA);
            d = rnd();
            wr(crtc_i + 10'h001, d);
            rd(crtc_i + 10'h001, d);
        end
        d = rnd();
        wr(PORT_SEQ_IDX, 8'h02);
        rd(PORT_SEQ_IDX, 8'h02);
        wr(PORT_SEQ_DAT, d);
        rd(PORT_SEQ_DAT, d);
        d = rnd();
        gwr(8'h05, d);
        rd(PORT_GFX_IDX, 8'h05);
        rd(PORT_GFX_DAT, d);
        $display("port map test done");

        // Two palette entries through auto-increment, the second shown as overscan with video off
        wr(PORT_PEL_MASK, 8'hff);
        // Four mask reads in a row reach the hidden register
        d = rnd();
        for (int k = 0; k < 10; k++)
            if (k == 4)
                wr(PORT_PEL_MASK, d);
            else
                rd(PORT_PEL_MASK, (k == 9) ? d : 8'hff);
        a = rnd();
        for (int k = 0; k < 6; k++)
            rgb[k] = rnd() & 8'h3f;
        wr(PORT_DAC_WADDR, a);
        rd(PORT_DAC_RADDR, {6'h00, DAC_STATE_WR});
        for (int k = 0; k < 6; k++)
            wr(PORT_DAC_DATA, rgb[k]);
        wr(PORT_DAC_RADDR, a);
        rd(PORT_DAC_RADDR, {6'h00, DAC_STATE_RD});
        for (int k = 0; k < 6; k++)
            rd(PORT_DAC_DATA, rgb[k]);
        vid_pixel_in = a;
        repeat (2) @(negedge clk_sys_in);
        check(vid_rgb_out, {rgb[0][5:0], rgb[1][5:0], rgb[2][5:0]});
        wr(PORT_ATTR_WR, {3'b000, OVERSCAN_IDX});
        wr(PORT_ATTR_WR, a + 8'h01);
        check(video_en_out, 1'b0);
        repeat (2) @(negedge clk_sys_in);
        check(vid_rgb_out, {rgb[3][5:0], rgb[4][5:0], rgb[5][5:0]});
        rd(PORT_ATTR_RD, a + 8'h01);
        grd(ATTR_MIRROR_IDX, {3'b000, OVERSCAN_IDX});
        $display("palette test done");

        // Second reset in mid-run locks again, after the last answer
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1'b0;
        repeat (2) @(negedge clk_sys_in);
        rstn_in = 1'b1;
        check(ext_access_out, 1'b0);
        grd(EXT_UNLOCK_IDX, 8'h00);
        $display("reset test done");
        repeat (3) @(negedge clk_sys_in);
        test_done();
    end
endmodule

// *** verif/vpdeu_host.sv ***
/*
 * Host CPU model issuing I/O read and write cycles to the port decoder.
 * Assumes the decoder samples strobes on the rising edge of clk_in.
 */
module vpdeu_host import vpdeu_pkg::*; (
    input wire logic clk_in,
    output logic [9:0] io_addr_out,
    output logic io_wr_out,
    output logic io_rd_out,
    output logic [7:0] io_wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==============================================================
    // Idle bus
    initial begin
        io_addr_out = 10'h000;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_wdata_out = 8'h00;
    end

    // ==============================================================
    // One strobe cycle, then an idle cycle
    // Released address and data lines show the inverse, so stale values never match
    task automatic access(input logic [9:0] addr, input logic wr,
                          input logic [7:0] data);
        @(negedge clk_in);
        io_addr_out = addr;
        io_wdata_out = data;
        io_wr_out = wr;
        io_rd_out = ~wr;
        @(negedge clk_in);
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_addr_out = ~addr;
        io_wdata_out = ~data;
    endtask

    // Index first, then the open or close code
    task automatic set_ext(input logic open);
        access(PORT_GFX_IDX, 1'b1, EXT_UNLOCK_IDX);
        access(PORT_GFX_DAT, 1'b1,
               open ? EXT_ENABLE_CODE : EXT_DISABLE_CODE);
    endtask
endmodule
